// file: src/emc_pkg.sv
// memory controller constants: request layout, widths, timing, states
// assumes emc_top alone joins the two clock sides
package emc_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int PIN_ADDR_W = 22;
  localparam int BA_W = 2;
  localparam int NUM_ACS = 3;
  localparam int CNT_W = 8;

  // request word: {write, region, address, byte enables, write data}
  localparam int REQ_WDATA_LSB = 0;
  localparam int REQ_BE_LSB = 16;
  localparam int REQ_ADDR_LSB = 18;
  localparam int REQ_REGION_LSB = 42;
  localparam int REQ_WRITE_BIT = 44;
  localparam int REQ_W = 45;

  localparam logic [1:0] REGION_SDRAM = 2'h0;

  // sdram timing in memory clock cycles
  localparam logic [CNT_W-1:0] T_RCD_CYC = 8'h02;
  localparam logic [CNT_W-1:0] T_RP_CYC = 8'h02;
  localparam logic [CNT_W-1:0] T_RC_CYC = 8'h06;
  localparam logic [CNT_W-1:0] T_WR_CYC = 8'h02;
  localparam logic [CNT_W-1:0] SLFR_CMD_CYC = 8'h01;
  localparam int REF_PERIOD_CYC = 390;
  // column bits: COL_BASE plus select code
  localparam logic [4:0] COL_BASE = 5'h08;
  // pin register plus data synchroniser
  localparam logic [CNT_W-1:0] RD_PIPE_CYC = 8'h03;
  localparam int CAP_PIPE = 3;
  localparam int PIN_A10 = 10;
  localparam int PIN_A11 = 11;
  localparam int ROW_W = 13;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ACT = 4'h1,
    ST_RCD = 4'h3,
    ST_RW = 4'h2,
    ST_CAS = 4'h6,
    ST_PRE = 4'h7,
    ST_RP = 4'h5,
    ST_DONE = 4'h4,
    ST_ASETUP = 4'hc,
    ST_ASTROBE = 4'hd,
    ST_AHOLD = 4'hf,
    ST_ATURN = 4'he,
    ST_REF = 4'h8,
    ST_RC = 4'h9,
    ST_SELFREF = 4'hb,
    ST_PDOWN = 4'ha
  } emc_state_t;
endpackage : emc_pkg

// file: src/emc_top.sv
// memory controller: request fifo on clk_in, pin sequencing on mem_clk_in
// assumes static configuration inputs; request and power inputs on clk_in

module emc_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW:0] wr_ff;
  logic [PW:0] rd_ff;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire full = (wr_ff[PW] != rd_ff[PW]) && (wr_ff[PW-1:0] == rd_ff[PW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = wr_ff != rd_ff;
  assign out_data_out = mem_ff[rd_ff[PW-1:0]];

  always_ff @(posedge clk_in) begin
    if (push) mem_ff[wr_ff[PW-1:0]] <= in_data_in;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule : emc_fifo

// Notes on behaviour
// R1: sixteen data lines, twenty-two address lines
// R2: three async selects, each own timing
// R3: sdram: one select, banks, columns, latency
// R4: self-refresh, powerdown with self-issued refreshes
// R5: operating clock driven out to sdram
// R6: one request serviced at a time
// R8: pending refresh runs before the request
// R9: precharge uses address bit ten all-banks
// R10: async address from address plus bank
// R11: two active-low byte lane enables
// R12: write strobe low only during strobe, sdram write command and precharge
// R13: read strobe low only during strobe
// R14: sdram select high only during async
// R15: row, column, select, write encode commands
// R16: clock enable issues self-refresh command
// R17: async select low only during access
// R18: wait input lengthens strobe, programmable polarity
// R19: strobe held while wait asserted, until the wait timeout count runs out
module emc_top #(
  parameter int FIFO_DEPTH = 8,
  parameter int REF_PERIOD = emc_pkg::REF_PERIOD_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic mem_clk_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic req_write_in,
  input wire logic [1:0] req_region_in,
  input wire logic [emc_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [1:0] req_byte_en_in,
  input wire logic [emc_pkg::DATA_W-1:0] req_wdata_in,
  output logic resp_valid_out,
  output logic [emc_pkg::DATA_W-1:0] resp_rdata_out,
  output logic resp_timeout_out,
  output logic busy_out,
  input wire logic sdram_self_refresh_in,
  input wire logic sdram_powerdown_in,
  input wire logic sdram_pd_refresh_in,
  input wire logic [1:0] sdram_cas_latency_in,
  input wire logic [1:0] sdram_bank_sel_in,
  input wire logic [1:0] sdram_col_sel_in,
  input wire logic [2:0][3:0] async_rd_setup_in,
  input wire logic [2:0][5:0] async_rd_strobe_in,
  input wire logic [2:0][2:0] async_rd_hold_in,
  input wire logic [2:0][3:0] async_wr_setup_in,
  input wire logic [2:0][5:0] async_wr_strobe_in,
  input wire logic [2:0][2:0] async_wr_hold_in,
  input wire logic [2:0][1:0] async_turnaround_in,
  input wire logic [2:0] async_region_config_wide_in,
  input wire logic [2:0] async_region_config_select_strobe_in,
  input wire logic [2:0] extended_wait_enable_in,
  input wire logic [2:0] wait_polarity_in,
  input wire logic [2:0][7:0] async_wait_timeout_in,
  input wire logic async_wait_in,
  output logic memory_clock_out_out,
  output logic sdram_clock_enable_out,
  output logic sdram_select_n_out,
  output logic row_strobe_n_out,
  output logic column_strobe_n_out,
  output logic write_strobe_n_out,
  output logic read_strobe_n_out,
  output logic [2:0] async_select_n_out,
  output logic [1:0] byte_lane_enable_n_out,
  output logic [emc_pkg::PIN_ADDR_W-1:0] mem_address_bus_out,
  output logic [emc_pkg::BA_W-1:0] mem_bank_address_out,
  input wire logic [emc_pkg::DATA_W-1:0] mem_data_bus_in,
  output logic [emc_pkg::DATA_W-1:0] mem_data_bus_out,
  output logic mem_data_bus_oe_out
);
  localparam int CW = emc_pkg::CNT_W;
  localparam int AW = emc_pkg::ADDR_W;
  localparam int DW = emc_pkg::DATA_W;

  // request side, clk_in
  logic f_valid;
  logic [emc_pkg::REQ_W-1:0] f_data;
  logic [emc_pkg::REQ_W-1:0] launch_ff;
  logic req_tgl_ff;
  logic busy_ff;
  logic dn_s1_ff, dn_s2_ff, dn_s3_ff;
  logic resp_valid_ff;
  logic [DW-1:0] resp_rdata_ff;
  logic resp_timeout_ff;
  logic done_tgl_ff;
  logic [DW-1:0] rdata_ff;
  logic timeout_ff;

  wire [emc_pkg::REQ_W-1:0] req_word = {req_write_in, req_region_in, req_addr_in,
                                         req_byte_en_in, req_wdata_in};
  wire launch = f_valid && !busy_ff; // R6
  wire done_evt = dn_s2_ff ^ dn_s3_ff;

  emc_fifo #(.WIDTH(emc_pkg::REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(req_valid_in),
    .in_ready_out(req_ready_out),
    .in_data_in(req_word),
    .out_valid_out(f_valid),
    .out_ready_in(launch),
    .out_data_out(f_data)
  );

  always_ff @(posedge clk_in) begin
    if (launch) launch_ff <= f_data;
    if (done_evt) resp_rdata_ff <= rdata_ff;
    if (done_evt) resp_timeout_ff <= timeout_ff;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      req_tgl_ff <= 1'b0;
      busy_ff <= 1'b0;
      dn_s1_ff <= 1'b0;
      dn_s2_ff <= 1'b0;
      dn_s3_ff <= 1'b0;
      resp_valid_ff <= 1'b0;
    end else begin
      dn_s1_ff <= done_tgl_ff;
      dn_s2_ff <= dn_s1_ff;
      dn_s3_ff <= dn_s2_ff;
      resp_valid_ff <= done_evt;
      if (launch) req_tgl_ff <= ~req_tgl_ff;
      if (launch) busy_ff <= 1'b1; // R6
      else if (done_evt) busy_ff <= 1'b0;
    end
  end

  assign resp_valid_out = resp_valid_ff;
  assign resp_rdata_out = resp_rdata_ff;
  assign resp_timeout_out = resp_timeout_ff;
  assign busy_out = busy_ff || f_valid;

  // memory side, mem_clk_in
  logic mrst_s1_ff, mrst_s2_ff;
  logic rq_s1_ff, rq_s2_ff, rq_seen_ff;
  logic sr_s1_ff, sr_s2_ff, pd_s1_ff, pd_s2_ff, pdr_s1_ff, pdr_s2_ff;
  logic wt_s1_ff, wt_s2_ff;
  logic [DW-1:0] dq_s1_ff, dq_s2_ff;
  emc_pkg::emc_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [7:0] to_ff, nxt_to;
  logic [$clog2(REF_PERIOD)-1:0] ref_cnt_ff;
  logic ref_pend_ff;
  logic cur_write_ff;
  logic [1:0] cur_region_ff;
  logic [AW-1:0] cur_addr_ff;
  logic [1:0] cur_be_ff;
  logic [DW-1:0] cur_wdata_ff;
  localparam int CAP_PIPE_W = emc_pkg::CAP_PIPE;
  logic [CAP_PIPE_W-1:0] cap_ff;
  logic nxt_timeout;

  wire mrst_n = mrst_s2_ff;
  wire new_req = rq_s2_ff ^ rq_seen_ff;
  wire take = (state_ff == emc_pkg::ST_IDLE) && !ref_pend_ff && !sr_s2_ff && !pd_s2_ff
              && new_req;
  wire is_sdram = launch_ff[emc_pkg::REQ_REGION_LSB +: 2] == emc_pkg::REGION_SDRAM;
  wire [1:0] cs_idx = cur_region_ff - 2'h1;
  wire [5:0] strobe_v = cur_write_ff ? async_wr_strobe_in[cs_idx] : async_rd_strobe_in[cs_idx];
  wire [2:0] hold_v = cur_write_ff ? async_wr_hold_in[cs_idx] : async_rd_hold_in[cs_idx];
  wire [1:0] turn_v = async_turnaround_in[cs_idx];
  wire ew = extended_wait_enable_in[cs_idx];
  wire wait_act = ew && (wt_s2_ff == wait_polarity_in[cs_idx]); // R18
  wire sel_strobe = async_region_config_select_strobe_in[cs_idx];
  wire wide = async_region_config_wide_in[cs_idx];
  wire [CW-1:0] cas_wait = CW'(sdram_cas_latency_in) + emc_pkg::RD_PIPE_CYC; // R3

  // sdram address split: column, then bank, then row
  wire [4:0] col_w = emc_pkg::COL_BASE + 5'(sdram_col_sel_in); // R3
  wire [4:0] bank_w = 5'(sdram_bank_sel_in);
  wire [AW-1:0] col_full = cur_addr_ff & ~({AW{1'b1}} << col_w);
  wire [AW-1:0] bank_full = (cur_addr_ff >> col_w) & ~({AW{1'b1}} << bank_w);
  wire [AW-1:0] row_full = cur_addr_ff >> (col_w + bank_w);

  function automatic logic [CW-1:0] cyc(input logic [CW-1:0] v);
    cyc = (v == '0) ? '0 : v - 1'b1;
  endfunction : cyc

  always_ff @(posedge mem_clk_in) begin
    mrst_s1_ff <= resetn_in;
    mrst_s2_ff <= mrst_s1_ff;
  end

  always_ff @(posedge mem_clk_in) begin
    if (!mrst_n) begin
      rq_s1_ff <= 1'b0;
      rq_s2_ff <= 1'b0;
      sr_s1_ff <= 1'b0;
      sr_s2_ff <= 1'b0;
      pd_s1_ff <= 1'b0;
      pd_s2_ff <= 1'b0;
      pdr_s1_ff <= 1'b0;
      pdr_s2_ff <= 1'b0;
      wt_s1_ff <= 1'b0;
      wt_s2_ff <= 1'b0;
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end else begin
      rq_s1_ff <= req_tgl_ff;
      rq_s2_ff <= rq_s1_ff;
      sr_s1_ff <= sdram_self_refresh_in;
      sr_s2_ff <= sr_s1_ff;
      pd_s1_ff <= sdram_powerdown_in;
      pd_s2_ff <= pd_s1_ff;
      pdr_s1_ff <= sdram_pd_refresh_in;
      pdr_s2_ff <= pdr_s1_ff;
      wt_s1_ff <= async_wait_in;
      wt_s2_ff <= wt_s1_ff;
      dq_s1_ff <= mem_data_bus_in;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // next state and wait counters
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff == '0) ? '0 : cnt_ff - 1'b1;
    nxt_to = to_ff;
    nxt_timeout = timeout_ff;
    case (state_ff)
      emc_pkg::ST_IDLE: begin
        if (ref_pend_ff) begin
          nxt_state = emc_pkg::ST_REF; // R8
        end else if (sr_s2_ff) begin
          nxt_state = emc_pkg::ST_SELFREF;
          nxt_cnt = emc_pkg::SLFR_CMD_CYC;
        end else if (pd_s2_ff) begin
          nxt_state = emc_pkg::ST_PDOWN;
        end else if (new_req) begin
          nxt_timeout = 1'b0;
          nxt_state = is_sdram ? emc_pkg::ST_ACT : emc_pkg::ST_ASETUP;
          nxt_cnt = '0;
        end
      end
      emc_pkg::ST_REF: begin
        nxt_state = emc_pkg::ST_RC;
        nxt_cnt = cyc(emc_pkg::T_RC_CYC);
      end
      emc_pkg::ST_RC: if (cnt_ff == '0) nxt_state = emc_pkg::ST_IDLE;
      emc_pkg::ST_SELFREF: begin
        if (!sr_s2_ff && cnt_ff == '0) begin
          nxt_state = emc_pkg::ST_RC;
          nxt_cnt = cyc(emc_pkg::T_RC_CYC);
        end
      end
      emc_pkg::ST_PDOWN: begin
        if (!pd_s2_ff || sr_s2_ff || (pdr_s2_ff && ref_pend_ff)) begin
          nxt_state = emc_pkg::ST_IDLE; // R4
        end
      end
      emc_pkg::ST_ACT: begin
        nxt_state = emc_pkg::ST_RCD;
        nxt_cnt = cyc(emc_pkg::T_RCD_CYC);
      end
      emc_pkg::ST_RCD: if (cnt_ff == '0) nxt_state = emc_pkg::ST_RW;
      emc_pkg::ST_RW: begin
        nxt_state = emc_pkg::ST_CAS;
        nxt_cnt = cur_write_ff ? cyc(emc_pkg::T_WR_CYC) : cas_wait;
      end
      emc_pkg::ST_CAS: if (cnt_ff == '0) nxt_state = emc_pkg::ST_PRE;
      emc_pkg::ST_PRE: begin
        nxt_state = emc_pkg::ST_RP;
        nxt_cnt = cyc(emc_pkg::T_RP_CYC);
      end
      emc_pkg::ST_RP: if (cnt_ff == '0) nxt_state = emc_pkg::ST_DONE;
      emc_pkg::ST_ASETUP: begin
        if (cnt_ff == '0) begin
          nxt_state = emc_pkg::ST_ASTROBE;
          nxt_cnt = cyc(CW'(strobe_v));
          nxt_to = async_wait_timeout_in[cs_idx];
        end
      end
      emc_pkg::ST_ASTROBE: begin
        if (cnt_ff == '0) begin
          if (wait_act && to_ff != '0) begin
            nxt_to = to_ff - 1'b1; // R19
          end else begin
            nxt_timeout = wait_act;
            nxt_state = emc_pkg::ST_AHOLD;
            nxt_cnt = cyc(CW'(hold_v));
          end
        end
      end
      emc_pkg::ST_AHOLD: begin
        if (cnt_ff == '0) begin
          nxt_state = emc_pkg::ST_ATURN;
          nxt_cnt = cyc(CW'(turn_v));
        end
      end
      emc_pkg::ST_ATURN: if (cnt_ff == '0 && cap_ff == '0) nxt_state = emc_pkg::ST_DONE;
      emc_pkg::ST_DONE: nxt_state = emc_pkg::ST_IDLE;
      default: nxt_state = emc_pkg::ST_IDLE;
    endcase
    if (state_ff == emc_pkg::ST_IDLE && nxt_state == emc_pkg::ST_ASETUP) begin
      nxt_cnt = cyc(CW'(launch_ff[emc_pkg::REQ_WRITE_BIT] ?
                 async_wr_setup_in[launch_ff[emc_pkg::REQ_REGION_LSB +: 2] - 2'h1] :
                 async_rd_setup_in[launch_ff[emc_pkg::REQ_REGION_LSB +: 2] - 2'h1]));
    end
  end

  wire strobe_last = (state_ff == emc_pkg::ST_ASTROBE) && (nxt_state == emc_pkg::ST_AHOLD);
  wire cas_cap = (state_ff == emc_pkg::ST_CAS) && !cur_write_ff && (cnt_ff == '0);
  wire ref_hit = ref_cnt_ff == '0;

  always_ff @(posedge mem_clk_in) begin
    if (!mrst_n) begin
      state_ff <= emc_pkg::ST_IDLE;
      cnt_ff <= '0;
      to_ff <= '0;
      ref_cnt_ff <= '0;
      ref_pend_ff <= 1'b0;
      rq_seen_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
      timeout_ff <= 1'b0;
      cap_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      to_ff <= nxt_to;
      timeout_ff <= nxt_timeout;
      cap_ff <= {cap_ff[CAP_PIPE_W-2:0], strobe_last && !cur_write_ff};
      ref_cnt_ff <= ref_hit ? ($clog2(REF_PERIOD))'(REF_PERIOD - 1) : ref_cnt_ff - 1'b1;
      // a refresh tick wins over a same-edge clear
      if (ref_hit) ref_pend_ff <= 1'b1;
      else if (state_ff == emc_pkg::ST_REF) ref_pend_ff <= 1'b0;
      if (take) rq_seen_ff <= rq_s2_ff;
      if (state_ff == emc_pkg::ST_DONE) done_tgl_ff <= ~done_tgl_ff;
    end
  end

  always_ff @(posedge mem_clk_in) begin
    if (take) begin
      cur_write_ff <= launch_ff[emc_pkg::REQ_WRITE_BIT];
      cur_region_ff <= launch_ff[emc_pkg::REQ_REGION_LSB +: 2];
      cur_addr_ff <= launch_ff[emc_pkg::REQ_ADDR_LSB +: AW];
      cur_be_ff <= launch_ff[emc_pkg::REQ_BE_LSB +: 2];
      cur_wdata_ff <= launch_ff[emc_pkg::REQ_WDATA_LSB +: DW];
    end
    if (cap_ff[CAP_PIPE_W-1] || cas_cap) rdata_ff <= dq_s2_ff;
  end

  // pin values, registered behind the state
  logic p_cke, p_sdcs_n, p_ras_n, p_cas_n, p_we_n, p_oe_n, p_dq_oe;
  logic [2:0] p_acs_n;
  logic [1:0] p_be_n;
  logic [emc_pkg::PIN_ADDR_W-1:0] p_addr;
  logic [emc_pkg::BA_W-1:0] p_ba;
  wire async_st = state_ff inside {emc_pkg::ST_ASETUP, emc_pkg::ST_ASTROBE,
                                   emc_pkg::ST_AHOLD};
  wire [2:0] cs_onehot = 3'h1 << cs_idx;

  always_comb begin
    p_cke = 1'b1;
    p_sdcs_n = async_st; // R14
    p_ras_n = 1'b1;
    p_cas_n = 1'b1;
    p_we_n = 1'b1;
    p_oe_n = 1'b1;
    p_acs_n = 3'h7;
    p_be_n = 2'h3;
    p_addr = '0;
    p_ba = '0;
    p_dq_oe = 1'b0;
    case (state_ff)
      emc_pkg::ST_REF: begin
        p_ras_n = 1'b0; // R15
        p_cas_n = 1'b0;
      end
      emc_pkg::ST_SELFREF: begin
        p_cke = 1'b0; // R16
        p_ras_n = cnt_ff == '0;
        p_cas_n = cnt_ff == '0;
      end
      emc_pkg::ST_PDOWN: p_cke = 1'b0; // R4
      emc_pkg::ST_ACT: begin
        p_ras_n = 1'b0; // R15
        p_ba = bank_full[1:0];
        p_addr = emc_pkg::PIN_ADDR_W'(row_full[emc_pkg::ROW_W-1:0]); // R3
      end
      emc_pkg::ST_RW: begin
        p_cas_n = 1'b0; // R15
        p_we_n = !cur_write_ff;
        p_ba = bank_full[1:0];
        p_be_n = ~cur_be_ff; // R11
        p_addr[9:0] = col_full[9:0];
        p_addr[emc_pkg::PIN_A11] = col_full[10];
        p_addr[emc_pkg::PIN_A10] = 1'b0;
        p_dq_oe = cur_write_ff;
      end
      emc_pkg::ST_CAS: p_be_n = ~cur_be_ff; // R11
      emc_pkg::ST_PRE: begin
        p_ras_n = 1'b0; // R15
        p_we_n = 1'b0;
        p_addr[emc_pkg::PIN_A10] = 1'b1; // R9
      end
      emc_pkg::ST_ASETUP, emc_pkg::ST_ASTROBE, emc_pkg::ST_AHOLD: begin
        p_addr = cur_addr_ff[AW-1:emc_pkg::BA_W]; // R10
        p_ba = cur_addr_ff[emc_pkg::BA_W-1:0];
        p_be_n = ~(cur_be_ff & {wide, 1'b1}); // R11
        p_dq_oe = cur_write_ff;
        if (!sel_strobe || state_ff == emc_pkg::ST_ASTROBE) p_acs_n = ~cs_onehot; // R17
        if (state_ff == emc_pkg::ST_ASTROBE) begin
          p_we_n = !cur_write_ff; // R12
          p_oe_n = cur_write_ff; // R13
        end
      end
      default: p_cke = 1'b1;
    endcase
  end

  always_ff @(posedge mem_clk_in) begin
    if (!mrst_n) begin
      sdram_clock_enable_out <= 1'b1;
      sdram_select_n_out <= 1'b0;
      row_strobe_n_out <= 1'b1;
      column_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      async_select_n_out <= 3'h7;
      byte_lane_enable_n_out <= 2'h3;
      mem_address_bus_out <= '0;
      mem_bank_address_out <= '0;
      mem_data_bus_out <= '0;
      mem_data_bus_oe_out <= 1'b0;
    end else begin
      sdram_clock_enable_out <= p_cke;
      sdram_select_n_out <= p_sdcs_n;
      row_strobe_n_out <= p_ras_n;
      column_strobe_n_out <= p_cas_n;
      write_strobe_n_out <= p_we_n;
      read_strobe_n_out <= p_oe_n;
      async_select_n_out <= p_acs_n;
      byte_lane_enable_n_out <= p_be_n;
      mem_address_bus_out <= p_addr; // R1
      mem_bank_address_out <= p_ba;
      mem_data_bus_out <= cur_wdata_ff;
      mem_data_bus_oe_out <= p_dq_oe;
    end
  end

  assign memory_clock_out_out = mem_clk_in; // R5
endmodule : emc_top

// file: verif/emc_mem_model.sv
// pin-level memory model: one sdram array and three async parts
// assumes single-word accesses; bench sets the wait length
module emc_mem_model #(
  parameter int CL = 2,
  parameter logic WAIT_HI = 1'h1
) (
  input wire logic clk_in,
  input wire logic [4:0] cmd_in,
  input wire logic [2:0] asel_n_in,
  input wire logic [5:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic data_oe_in,
  input wire logic [7:0] wait_len_in,
  output logic [15:0] data_out = 16'h5a5a,
  output logic wait_out = 1'h0
);
  // cmd_in {cs_n, ras_n, cas_n, we_n, oe_n}; addr_in {bank, low address}
  logic [15:0] mem [64];
  logic [3:0] rd_sr = 4'h0;
  logic [1:0] hold = 2'h0;
  logic [7:0] wcnt = 8'h0;
  logic [5:0] sidx = 6'h0;
  wire logic [2:0] s = ~asel_n_in;
  wire logic [1:0] kind = s[0] ? 2'h1 : (s[1] ? 2'h2 : (s[2] ? 2'h3 : 2'h0));
  wire logic col = !cmd_in[4] && cmd_in[3] && !cmd_in[2];
  wire logic strb = cmd_in[4] && !(cmd_in[1] && cmd_in[0]);
  wire logic rd = strb && !cmd_in[0];
  wire logic [5:0] aidx = {kind, addr_in[5:4], addr_in[1:0]};
  wire logic [5:0] idx = col ? {2'h0, addr_in[3:0]} : (strb ? aidx : sidx);
  always @(posedge clk_in) begin
    rd_sr <= {rd_sr[2:0], col && cmd_in[1]};
    sidx <= idx;
    if ((col || (strb && data_oe_in)) && !cmd_in[1]) mem[idx] <= data_in;
    hold <= rd ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
    // released bus flips every cycle so stale data never looks valid
    data_out <= (rd || hold > 2'h1 || |rd_sr[CL:CL-2]) ? mem[idx] : ~data_out;
    wcnt <= strb ? wcnt + 8'h1 : 8'h0;
    wait_out <= (strb && wcnt < wait_len_in) == WAIT_HI;
  end
endmodule : emc_mem_model

// file: verif/emc_monitor.sv
// pin assertions for emc_top on the memory clock
// assumes watched pins are registered on mem_clk_in
module emc_monitor (
  input wire logic resetn_in,
  input wire logic mem_clk_in,
  input wire logic sdram_clock_enable_out,
  input wire logic sdram_select_n_out,
  input wire logic row_strobe_n_out,
  input wire logic column_strobe_n_out,
  input wire logic write_strobe_n_out,
  input wire logic read_strobe_n_out,
  input wire logic [2:0] async_select_n_out,
  input wire logic [emc_pkg::PIN_ADDR_W-1:0] mem_address_bus_out,
  input wire logic mem_data_bus_oe_out
);
  default clocking @(posedge mem_clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic cs = !sdram_select_n_out;
  wire logic ras = !row_strobe_n_out;
  wire logic cas = !column_strobe_n_out;
  wire logic we = !write_strobe_n_out;
  wire logic oe = !read_strobe_n_out;
  wire logic asel = !(&async_select_n_out);
  wire logic cke = sdram_clock_enable_out;
  wire logic a10 = mem_address_bus_out[emc_pkg::PIN_A10];
  rd_strobe_gate_a: assert property (oe |-> !cs && asel && !we)
    else $error("read strobe outside an async read");
  wr_strobe_gate_a: assert property (we && !cs |-> asel && mem_data_bus_oe_out)
    else $error("async write strobe without select or data drive");
  one_select_a: assert property ($onehot0(~async_select_n_out))
    else $error("two async selects low");
  sdram_deselect_a: assert property (asel |-> !cs)
    else $error("sdram select low during async access");
  sdram_reselect_a: assert property ($rose(sdram_select_n_out) |-> ##[1:400] cs)
    else $error("sdram select not restored");
  pre_all_banks_a: assert property (cke && cs && ras && !cas && we |-> a10)
    else $error("precharge without all-bank bit");
  col_no_autopre_a: assert property (cs && !ras && cas |-> !a10)
    else $error("column command with bit ten set");
  slfr_cmd_a: assert property (!cke && ras |-> (cas && !we && cs) ##1 (!ras && !cas))
    else $error("bad self refresh command");
  cover property (oe ##1 !oe);
  cover property (we && !cs);
  cover property (!cke ##1 cke);
endmodule : emc_monitor

bind emc_top emc_monitor mon_u (.resetn_in, .mem_clk_in, .sdram_clock_enable_out,
  .sdram_select_n_out, .row_strobe_n_out, .column_strobe_n_out, .write_strobe_n_out,
  .read_strobe_n_out, .async_select_n_out, .mem_address_bus_out, .mem_data_bus_oe_out);

// file: verif/testbench.sv
// self-checking bench for emc_top with a pin-level memory model
// assumes the model returns the last word written
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
  logic clk_in = 1'h0, mem_clk_in = 1'h0, resetn_in = 1'h0, req_valid_in = 1'h0;
  logic req_write_in = 1'h0, sr = 1'h0, pd = 1'h0, pdr = 1'h0;
  logic [1:0] req_region_in = 2'h0, req_byte_en_in = 2'h3, sd_be_n = 2'h3;
  logic [23:0] req_addr_in = 24'h0;
  logic [15:0] req_wdata_in = 16'h0;
  logic [7:0] wait_len = 8'h0;
  logic [2:0][3:0] su = 12'h222;
  logic [2:0][5:0] sb = 18'h06186;
  logic [2:0][2:0] hd = 9'h092;
  logic [2:0] wd = 3'h7, ss = 3'h2, ew = 3'h1, wp = 3'h1;
  int mismatches = 0, checks_done = 0, resp_cnt = 0, stalls = 0;
  int run_len = 0, last_len = 0, refs = 0;
  wire logic req_ready_out, resp_valid_out, resp_timeout_out, busy_out, clk_o, cke, cs_n;
  wire logic ras_n, cas_n, we_n, oe_n, doe, wt;
  wire logic [2:0] as_n;
  wire logic [1:0] be_n, ba;
  wire logic [21:0] a;
  wire logic [15:0] resp_rdata_out, din, dout;
  emc_top #(.REF_PERIOD(40)) dut_u (.clk_in, .resetn_in, .mem_clk_in, .req_valid_in,
    .req_ready_out, .req_write_in, .req_region_in, .req_addr_in, .req_byte_en_in,
    .req_wdata_in, .resp_valid_out, .resp_rdata_out, .resp_timeout_out, .busy_out,
    .sdram_self_refresh_in(sr), .sdram_powerdown_in(pd), .sdram_pd_refresh_in(pdr),
    .sdram_cas_latency_in(2'h2), .sdram_bank_sel_in(2'h2), .sdram_col_sel_in(2'h0),
    .async_rd_setup_in(su), .async_rd_strobe_in(sb), .async_rd_hold_in(hd),
    .async_wr_setup_in(su), .async_wr_strobe_in(sb), .async_wr_hold_in(hd),
    .async_turnaround_in({3{2'h1}}), .async_region_config_wide_in(wd),
    .async_region_config_select_strobe_in(ss), .extended_wait_enable_in(ew),
    .wait_polarity_in(wp), .async_wait_timeout_in({3{8'h08}}), .async_wait_in(wt),
    .memory_clock_out_out(clk_o), .sdram_clock_enable_out(cke), .sdram_select_n_out(cs_n),
    .row_strobe_n_out(ras_n), .column_strobe_n_out(cas_n), .write_strobe_n_out(we_n),
    .read_strobe_n_out(oe_n), .async_select_n_out(as_n), .byte_lane_enable_n_out(be_n),
    .mem_address_bus_out(a), .mem_bank_address_out(ba), .mem_data_bus_in(din),
    .mem_data_bus_out(dout), .mem_data_bus_oe_out(doe));
  emc_mem_model mem_u (.clk_in(mem_clk_in), .cmd_in({cs_n, ras_n, cas_n, we_n, oe_n}),
    .asel_n_in(as_n), .addr_in({ba, a[3:0]}), .data_in(dout), .data_oe_in(doe),
    .wait_len_in(wait_len), .data_out(din), .wait_out(wt));
  initial begin forever #12.5 clk_in = ~clk_in; end
  initial begin #1; forever begin mem_clk_in = ~mem_clk_in; #24; end end
  always @(negedge clk_in) begin if (resp_valid_out === 1'h1) resp_cnt++; end
  always @(negedge mem_clk_in) begin
    if (cke && !cs_n && !ras_n && !cas_n && we_n) refs++;
    if (!cs_n && ras_n && !cas_n && !we_n) sd_be_n = be_n;
    if (!oe_n) run_len++;
    else if (run_len > 0) begin last_len = run_len; run_len = 0; end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wait_resp(input int target);
    int n;
    n = 0;
    while (resp_cnt < target && n < 5000) begin @(negedge clk_in); n++; end
    if (n == 5000) begin
      mismatches++;
      $display("Error at %0t: no response", $time);
      print_verdict();
    end
  endtask : wait_resp
  // one request per call, held until the fifo accepts it
  task automatic push(input logic w, input logic [1:0] rg, input logic [23:0] ad,
      input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    req_valid_in = 1'h1;
    {req_write_in, req_region_in, req_addr_in, req_wdata_in} = {w, rg, ad, d};
    while (req_ready_out !== 1'h1 && n < 500) begin @(negedge clk_in); n++; end
    if (n > 0) stalls++;
    if (n == 500) wait_resp(1 << 30);
    @(negedge clk_in);
    req_valid_in = 1'h0;
  endtask : push
  task automatic access(input logic w, input logic [1:0] rg, input logic [23:0] ad);
    int t;
    t = resp_cnt + 1;
    push(w, rg, ad, 16'(rg * 256) + ad[15:0]);
    wait_resp(t);
  endtask : access
  initial begin
    int base;
    repeat (5) @(negedge clk_in);
    resetn_in = 1'h1;
    repeat (4) @(negedge clk_in);
    `CHK(cs_n, 1'h0)
    `CHK(cke, 1'h1)
    `CHK(clk_o, mem_clk_in)
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 2; i++) access(1'h1, r[1:0], 24'(5 * i + 16));
      for (int i = 0; i < 2; i++) begin
        access(1'h0, r[1:0], 24'(5 * i + 16));
        `CHK(resp_rdata_out, 16'(r * 256 + 5 * i + 16))
      end
    end
    req_byte_en_in = 2'h1;
    access(1'h1, 2'h0, 24'h000030);
    req_byte_en_in = 2'h3;
    `CHK(sd_be_n, 2'h2)
    $display("test readback done");
    access(1'h0, 2'h1, 24'h000010);
    `CHK(last_len, 6)
    wait_len = 8'h08;
    access(1'h0, 2'h1, 24'h000010);
    `CHK(resp_rdata_out, 16'h0110)
    `CHK(last_len > 8, 1'h1)
    `CHK(resp_timeout_out, 1'h0)
    wait_len = 8'h3c;
    access(1'h0, 2'h1, 24'h000010);
    `CHK(resp_timeout_out, 1'h1)
    wait_len = 8'h00;
    $display("test wait done");
    sr = 1'h1;
    repeat (100) @(negedge clk_in);
    `CHK(cke, 1'h0)
    sr = 1'h0;
    pd = 1'h1;
    pdr = 1'h1;
    base = refs;
    repeat (400) @(negedge clk_in);
    `CHK(refs > base + 1, 1'h1)
    pd = 1'h0;
    pdr = 1'h0;
    access(1'h0, 2'h0, 24'h000015);
    `CHK(resp_rdata_out, 16'h0015)
    $display("test power done");
    base = resp_cnt;
    for (int i = 0; i < 10; i++) push(1'h1, 2'h2, 24'(i), 16'(i + 4096));
    wait_resp(base + 10);
    `CHK(stalls > 0, 1'h1)
    for (int i = 0; i < 10; i += 3) begin
      push(1'h0, 2'h2, 24'(i), 16'h0000);
      wait_resp(base + 11 + i / 3);
      `CHK(resp_rdata_out, 16'(i + 4096))
    end
    `CHK(busy_out, 1'h0)
    $display("test queue done");
    print_verdict();
  end
endmodule : testbench
